// ===== osc_model.sv
// oscillator partner: ready flags follow enables after a start-up delay
`timescale 1ns/10ps
module osc_model
#(
  parameter int FAST_DLY = 12,
  parameter int SLOW_DLY = 6
)
(
  input wire logic mclk,
  input wire logic fast_osc_on,
  input wire logic low_speed_internal_osc_on,
  output logic fast_osc_ready,
  output logic low_speed_internal_osc_ready
);
  int fast_cnt = 0;
  int slow_cnt = 0;
  // ==========================================================
  // start-up counters, no ready while stopped
  always @(posedge mclk)
  begin
    fast_cnt <= fast_osc_on ? fast_cnt + 1 : 0;
    slow_cnt <= low_speed_internal_osc_on ? slow_cnt + 1 : 0;
  end
  assign fast_osc_ready = fast_osc_on && fast_cnt >= FAST_DLY;
  assign low_speed_internal_osc_ready = low_speed_internal_osc_on && slow_cnt >= SLOW_DLY;
endmodule

// ===== pmw_pkg.sv
// shared constants and types for the power mode and wake controller
package pmw_pkg;
  // ==========================================================
  // clocking and timing
  localparam int MCLK_HZ = 40000000;
  localparam int LOW_SPEED_INTERNAL_OSC_HZ = 32000;
  localparam int SLOW_DIV_DEF = MCLK_HZ / LOW_SPEED_INTERNAL_OSC_HZ;
  localparam logic [2:0] SWITCH_SYS_PERIODS = 3'h4;
  localparam int PORTA_W_DEF = 8;
  localparam int IRQ_N_DEF = 4;
  localparam int WDT_CNT_W = 16;
  localparam logic [4:0] WDT_BASE_EXP = 5'h08;
  // ==========================================================
  // register map
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [3:0] REG_CLK = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h1;
  localparam logic [3:0] REG_WAKE = 4'h2;
  localparam logic [3:0] REG_WDT = 4'h3;
  localparam logic [3:0] REG_MODE = 4'h4;
  // ==========================================================
  // field positions
  localparam int F_SEL_LO = 5;
  localparam int F_SEL_HI = 7;
  localparam int F_PEND = 4;
  localparam int F_FAST_FLAG = 3;
  localparam int F_FAST_EN = 2;
  localparam int F_KEEP_FAST = 1;
  localparam int F_KEEP_SLOW = 0;
  localparam int F_PDF = 1;
  localparam int F_EXPIRY = 0;
  localparam int F_WDT_EN = 3;
  localparam int F_WDT_SEL_HI = 2;
  localparam int F_WDT_SEL_LO = 0;
  // ==========================================================
  // reset values and codes
  localparam logic [2:0] SEL_RST = 3'h7;
  localparam logic [2:0] SEL_SLOW = 3'h7;
  localparam logic WDT_EN_RST = 1'h1;
  localparam logic [2:0] WDT_SEL_RST = 3'h7;
  // ==========================================================
  // types
  typedef enum logic [1:0] {
    st_run = 2'h0,
    st_halt = 2'h1,
    st_wake = 2'h2
  } pm_state_t;
  typedef enum logic [1:0] {
    mode_sleep = 2'h0,
    idle_slow_only = 2'h1,
    idle_fast_only = 2'h2,
    idle_both_clocks = 2'h3
  } halt_mode_t;
  typedef enum logic [2:0] {
    cause_pin = 3'h0,
    cause_irq_resume = 3'h1,
    cause_irq_vector = 3'h2,
    cause_wdt = 3'h3,
    cause_ext = 3'h4
  } wake_cause_t;
endpackage

// ===== pmw_props.sv
// port-level assertion checker for the power mode and wake controller
`timescale 1ns/10ps
module pmw_props
  import pmw_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic suspend_exec,
  input wire logic external_reset_pin_n,
  input wire logic fast_osc_on,
  input wire logic cpu_run,
  input wire logic resume_pulse,
  input wire logic vector_pulse,
  input wire logic full_reset_pulse,
  input wire logic pcsp_reset_pulse
);
  logic keep_fast;
  wire logic [3:0] wake = {pcsp_reset_pulse, full_reset_pulse, vector_pulse, resume_pulse};
  // ==========================================================
  // keep bit shadow, seen from bus writes only
  always_ff @(posedge mclk)
  begin
    if (!nrst)
      keep_fast <= 1'h0;
    else if (reg_wr && reg_addr == REG_CLK)
      keep_fast <= reg_wdata[F_KEEP_FAST];
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  // ==========================================================
  // sequences and properties
  sequence s_suspend;
    cpu_run && suspend_exec;
  endsequence
  sequence s_continue;
    resume_pulse || vector_pulse || pcsp_reset_pulse;
  endsequence
  AST_HALT_ENTRY: assert property (s_suspend |=> !cpu_run)
    else $error("core still running after suspend");
  AST_HALT_CAUSE: assert property ($fell(cpu_run) |-> $past(suspend_exec))
    else $error("core halted without suspend");
  AST_WAKE_ONE: assert property ($onehot0(wake))
    else $error("more than one wake pulse");
  // run flag follows the wake pulse by one cycle
  AST_WAKE_RUN: assert property (s_continue |=> $rose(cpu_run))
    else $error("wake pulse not paired with core restart");
  AST_RUN_CAUSE: assert property ($rose(cpu_run) |-> $past(wake) != 4'h0)
    else $error("core restarted without wake pulse");
  AST_SLEEP_FAST_OFF: assert property (s_suspend ##0 !keep_fast |-> ##[1:3] !fast_osc_on)
    else $error("fast oscillator kept in sleep or idle slow");
  AST_IDLE_FAST_ON: assert property (s_suspend ##0 keep_fast && fast_osc_on |=> fast_osc_on [*3])
    else $error("fast oscillator stopped in idle");
  AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read cycle");
  AST_RESET_PIN: assert property ($fell(external_reset_pin_n) |-> ##[1:80] full_reset_pulse)
    else $error("reset pin gave no full reset");
endmodule

bind power_mode_wake_controller pmw_props u_props (.mclk(mclk), .nrst(nrst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .suspend_exec(suspend_exec),
  .external_reset_pin_n(external_reset_pin_n), .fast_osc_on(fast_osc_on),
  .cpu_run(cpu_run), .resume_pulse(resume_pulse), .vector_pulse(vector_pulse),
  .full_reset_pulse(full_reset_pulse), .pcsp_reset_pulse(pcsp_reset_pulse));

// ===== power_mode_wake_controller.sv
// clock select, halt modes, watchdog flags and wake-up sequencing
//
// The implementer's own choices: the register addresses and the strobed register port.
`timescale 1ns/10ps
module power_mode_wake_controller
  import pmw_pkg::*;
#(
  parameter int PORTA_W = PORTA_W_DEF,
  parameter int IRQ_N = IRQ_N_DEF,
  parameter int SLOW_DIV = SLOW_DIV_DEF
)
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic suspend_exec,
  input wire logic watchdog_clear_instruction,
  input wire logic [IRQ_N-1:0] irq_req,
  input wire logic [IRQ_N-1:0] irq_enable,
  input wire logic stack_full,
  input wire logic [PORTA_W-1:0] porta_pin,
  input wire logic external_reset_pin_n,
  input wire logic fast_osc_ready,
  input wire logic low_speed_internal_osc_ready,
  output logic fast_osc_on,
  output logic low_speed_internal_osc_on,
  output logic sysclk_tick,
  output logic cpu_run,
  output logic resume_pulse,
  output logic vector_pulse,
  output logic full_reset_pulse,
  output logic wdt_reset_pulse,
  output logic pcsp_reset_pulse
);
  localparam int SYNC_W = PORTA_W + 3;
  localparam int SLOW_W = $clog2(SLOW_DIV);
  localparam logic [SLOW_W-1:0] SLOW_LAST = SLOW_W'(SLOW_DIV - 1);
  localparam int I_EXT = 2;
  localparam int I_FAST = 1;
  localparam int I_LOW_SPEED_INTERNAL_OSC = 0;

  // ==========================================================
  // parameter check
  if (PORTA_W < 1 || PORTA_W > DATA_W || IRQ_N < 1 || SLOW_DIV < 2)
  begin : bad_params
    $error("power_mode_wake_controller: unsupported parameters");
  end

  // ==========================================================
  // helpers
  function automatic logic div_hit(input logic [5:0] cnt, input logic [2:0] sel);
    div_hit = (cnt & ((6'h01 << sel) - 6'h01)) == 6'h00;
  endfunction

  function automatic logic tick_of(input logic [2:0] sel, input logic [5:0] cnt,
                                   input logic slow_t, input logic fast_ok);
    // slow code ticks on the slow clock
    if (sel == SEL_SLOW)
      tick_of = slow_t;
    // fast codes divide by two to the code
    else
      tick_of = fast_ok && div_hit(cnt, sel);
  endfunction

  // ==========================================================
  // state
  pm_state_t state;
  halt_mode_t halt_mode;
  wake_cause_t cause;
  logic [2:0] sel_reg;
  logic [2:0] active_sel;
  logic sw_pend;
  logic [2:0] sw_cnt;
  logic fast_en;
  logic keep_fast;
  logic keep_slow;
  logic fast_flag;
  logic powerdown_flag;
  logic expiry;
  logic [PORTA_W-1:0] wake_en;
  logic wdt_en;
  logic [2:0] wdt_sel;
  logic [IRQ_N-1:0] irq_armed;
  logic [5:0] fast_div;
  logic [SLOW_W-1:0] slow_div;
  logic [SYNC_W-1:0] sync1;
  logic [SYNC_W-1:0] sync2;
  logic [SYNC_W-1:0] sync3;
  logic [SYNC_W-1:0] pin_filt;

  watchdog_link_if wd ();

  watchdog_counter u_wdt (
    .mclk (mclk),
    .nrst (nrst),
    .link (wd)
  );

  // ==========================================================
  // pin synchronisers
  wire [SYNC_W-1:0] pin_raw = {porta_pin, external_reset_pin_n,
                               fast_osc_ready, low_speed_internal_osc_ready};
  wire [SYNC_W-1:0] pin_rst = {{(PORTA_W+1){1'b1}}, 2'h0};
  // a change counts only once two late stages agree
  wire [SYNC_W-1:0] agree = ~(sync2 ^ sync3);
  wire [SYNC_W-1:0] next_pin_filt = (sync3 & agree) | (pin_filt & ~agree);

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      sync1 <= pin_rst;
      sync2 <= pin_rst;
      sync3 <= pin_rst;
      pin_filt <= pin_rst;
    end
    else
    begin
      sync1 <= pin_raw;
      sync2 <= sync1;
      sync3 <= sync2;
      pin_filt <= next_pin_filt;
    end
  end

  wire [PORTA_W-1:0] porta_now = pin_filt[SYNC_W-1:3];
  wire [PORTA_W-1:0] porta_next = next_pin_filt[SYNC_W-1:3];
  wire porta_fall = |(porta_now & ~porta_next & wake_en);
  wire ext_fall = pin_filt[I_EXT] && !next_pin_filt[I_EXT];

  // ==========================================================
  // register decode
  wire wr_clk = reg_wr && reg_addr == REG_CLK;
  wire wr_wake = reg_wr && reg_addr == REG_WAKE;
  wire wr_wdt = reg_wr && reg_addr == REG_WDT;
  wire [2:0] wr_sel = reg_wdata[F_SEL_HI:F_SEL_LO];

  wire [DATA_W-1:0] rd_clk = {sel_reg, sw_pend, fast_flag, fast_en, keep_fast, keep_slow};
  wire [DATA_W-1:0] rd_stat = {6'h00, powerdown_flag, expiry};
  wire [DATA_W-1:0] rd_wake = DATA_W'(wake_en);
  wire [DATA_W-1:0] rd_wdt = {4'h0, wdt_en, wdt_sel};
  wire [DATA_W-1:0] rd_mode = {3'h0, active_sel, state};
  wire [DATA_W-1:0] rd_mux = reg_addr == REG_CLK ? rd_clk :
                             reg_addr == REG_STAT ? rd_stat :
                             reg_addr == REG_WAKE ? rd_wake :
                             reg_addr == REG_WDT ? rd_wdt :
                             reg_addr == REG_MODE ? rd_mode : 8'h00;

  // ==========================================================
  // clock dividers and source ticks
  wire low_speed_internal_osc_ok = low_speed_internal_osc_on && pin_filt[I_LOW_SPEED_INTERNAL_OSC];
  wire fast_ok = fast_osc_on && fast_flag;
  wire slow_tick = low_speed_internal_osc_ok && slow_div == '0;
  wire sys_tick_raw = tick_of(active_sel, fast_div, slow_tick, fast_ok);
  wire target_tick = tick_of(sel_reg, fast_div, slow_tick, fast_ok);
  wire sw_count_done = sw_cnt == SWITCH_SYS_PERIODS;
  wire sw_start = wr_clk && wr_sel != active_sel;

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      fast_div <= 6'h00;
      slow_div <= '0;
    end
    else
    begin
      fast_div <= fast_div + 6'h01;
      if (low_speed_internal_osc_ok)
        slow_div <= slow_div == SLOW_LAST ? '0 : slow_div + 1'b1;
    end
  end

  // ==========================================================
  // clock switching
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      active_sel <= SEL_RST;
      sw_pend <= 1'b0;
      sw_cnt <= 3'h0;
    end
    else if (sw_start)
    begin
      sw_pend <= 1'b1;
      sw_cnt <= 3'h0;
    end
    else if (sw_pend)
    begin
      if (!sw_count_done)
      begin
        if (sys_tick_raw)
          sw_cnt <= sw_cnt + 3'h1;
      end
      // target edge needs a stable source
      else if (target_tick)
      begin
        active_sel <= sel_reg;
        sw_pend <= 1'b0;
      end
    end
    else if (wr_clk)
    begin
      sw_cnt <= 3'h0;
    end
  end

  // ==========================================================
  // oscillator requests
  wire need_fast = fast_en || active_sel != SEL_SLOW || (sw_pend && sel_reg != SEL_SLOW);
  wire need_slow = active_sel == SEL_SLOW || (sw_pend && sel_reg == SEL_SLOW);
  wire halted = state == st_halt;
  // sleep drops both clocks, watchdog excepted
  wire next_fast_on = halted ? halt_mode[1] : need_fast;
  wire next_low_speed_internal_osc_on = wdt_en || (halted ? halt_mode[0] : need_slow);
  // flag low while off, set once ready seen
  wire next_fast_flag = next_fast_on && fast_osc_on && (fast_flag || pin_filt[I_FAST]);

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      fast_osc_on <= 1'b0;
      low_speed_internal_osc_on <= 1'b0;
      fast_flag <= 1'b0;
    end
    else
    begin
      fast_osc_on <= next_fast_on;
      low_speed_internal_osc_on <= next_low_speed_internal_osc_on;
      // restart after slow mode shows here
      fast_flag <= next_fast_flag;
    end
  end

  // ==========================================================
  // software registers
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      sel_reg <= SEL_RST;
      fast_en <= 1'b0;
      keep_fast <= 1'b0;
      keep_slow <= 1'b0;
      wake_en <= '0;
      wdt_en <= WDT_EN_RST;
      wdt_sel <= WDT_SEL_RST;
      reg_rdata <= 8'h00;
    end
    else
    begin
      if (wr_clk)
      begin
        sel_reg <= wr_sel;
        fast_en <= reg_wdata[F_FAST_EN];
        keep_fast <= reg_wdata[F_KEEP_FAST];
        keep_slow <= reg_wdata[F_KEEP_SLOW];
      end
      if (wr_wake)
        wake_en <= reg_wdata[PORTA_W-1:0];
      if (wr_wdt)
      begin
        wdt_en <= reg_wdata[F_WDT_EN];
        wdt_sel <= reg_wdata[F_WDT_SEL_HI:F_WDT_SEL_LO];
      end
      // read data stands for one cycle only
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
    end
  end

  // ==========================================================
  // watchdog link and flags
  wire suspend_taken = state == st_run && suspend_exec;
  wire wdt_ovf = wd.overflow;

  // cleared on halt entry, clear instruction and reset pin fall
  assign wd.clear = suspend_taken || watchdog_clear_instruction || ext_fall;
  assign wd.tick = slow_tick;
  assign wd.enable = wdt_en;
  assign wd.period_sel = wdt_sel;

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      powerdown_flag <= 1'b0;
      expiry <= 1'b0;
    end
    else
    begin
      // entry sets powerdown, set beats clear
      if (suspend_taken)
        powerdown_flag <= 1'b1;
      else if (watchdog_clear_instruction)
        powerdown_flag <= 1'b0;
      if (wdt_ovf)
        expiry <= 1'b1;
      else if (suspend_taken)
        expiry <= 1'b0;
    end
  end

  // ==========================================================
  // wake decode
  // requests already set at entry are masked
  wire [IRQ_N-1:0] irq_new = irq_req & ~irq_armed;
  wire irq_wake = |irq_new;
  // enabled irq with stack room takes vector
  wire irq_vec = |(irq_new & irq_enable) && !stack_full;
  // resume waits for the system source
  wire wake_clk_ok = active_sel == SEL_SLOW ? low_speed_internal_osc_ok : fast_ok;
  wire ext_low = !pin_filt[I_EXT];

  // priority: reset pin, watchdog, irq, port A
  wire wake_any = ext_low || wdt_ovf || irq_wake || porta_fall;
  wire [2:0] next_cause = ext_low ? cause_ext :
                          wdt_ovf ? cause_wdt :
                          irq_wake ? (irq_vec ? cause_irq_vector : cause_irq_resume) :
                          cause_pin;

  // ==========================================================
  // mode sequencer
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      state <= st_run;
      halt_mode <= mode_sleep;
      cause <= cause_pin;
      irq_armed <= '0;
      resume_pulse <= 1'b0;
      vector_pulse <= 1'b0;
      full_reset_pulse <= 1'b0;
      wdt_reset_pulse <= 1'b0;
      pcsp_reset_pulse <= 1'b0;
    end
    else
    begin
      resume_pulse <= 1'b0;
      vector_pulse <= 1'b0;
      full_reset_pulse <= 1'b0;
      wdt_reset_pulse <= 1'b0;
      pcsp_reset_pulse <= 1'b0;
      unique case (state)
        st_run:
        begin
          if (ext_fall)
            full_reset_pulse <= 1'b1;
          else if (wdt_ovf)
            wdt_reset_pulse <= 1'b1;
          else if (suspend_exec)
          begin
            // core freezes; halt mode and the irq requests at entry are latched
            state <= st_halt;
            halt_mode <= halt_mode_t'({keep_fast, keep_slow});
            irq_armed <= irq_req;
          end
        end
        st_halt:
        begin
          if (wake_any)
          begin
            state <= st_wake;
            cause <= wake_cause_t'(next_cause);
          end
        end
        st_wake:
        begin
          if (wake_clk_ok)
          begin
            state <= st_run;
            unique case (cause)
              // reset pin wake gives full reset
              cause_ext: full_reset_pulse <= 1'b1;
              // watchdog wake resets pc and sp only
              cause_wdt: pcsp_reset_pulse <= 1'b1;
              cause_irq_vector: vector_pulse <= 1'b1;
              cause_irq_resume: resume_pulse <= 1'b1;
              cause_pin: resume_pulse <= 1'b1;
              default: resume_pulse <= 1'b1;
            endcase
          end
        end
        default: state <= st_run;
      endcase
    end
  end

  // ==========================================================
  // core clock enable
  // halting stops the tick, so core state simply holds
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      sysclk_tick <= 1'b0;
      cpu_run <= 1'b1;
    end
    else
    begin
      // no core tick while halted or waking
      sysclk_tick <= state == st_run && !suspend_exec && sys_tick_raw;
      cpu_run <= state == st_run && !suspend_exec;
    end
  end
endmodule

// ===== power_mode_wake_controller_test.sv
// self-checking bench for the power mode and wake controller
`timescale 1ns/10ps
module power_mode_wake_controller_test
  import pmw_pkg::*;
;
  localparam int SDIV = 4;
  logic mclk = 1'h0, nrst = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, suspend_exec = 1'h0;
  logic watchdog_clear_instruction = 1'h0, stack_full = 1'h0, external_reset_pin_n = 1'h1;
  logic [3:0] reg_addr = 4'h0, irq_req = 4'h0, irq_enable = 4'h0;
  logic [7:0] reg_wdata = 8'h00, porta_pin = 8'hff, reg_rdata;
  logic fast_osc_ready, low_speed_internal_osc_ready, fast_osc_on, low_speed_internal_osc_on;
  logic sysclk_tick, cpu_run, resume_pulse, vector_pulse;
  logic full_reset_pulse, wdt_reset_pulse, pcsp_reset_pulse;
  int n_errors = 0;
  int checked = 0;
  always #12.5 mclk = ~mclk;
  power_mode_wake_controller #(.PORTA_W(8), .IRQ_N(4), .SLOW_DIV(SDIV)) u_dut (.mclk(mclk),
    .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .suspend_exec(suspend_exec),
    .watchdog_clear_instruction(watchdog_clear_instruction), .irq_req(irq_req),
    .irq_enable(irq_enable), .stack_full(stack_full), .porta_pin(porta_pin),
    .external_reset_pin_n(external_reset_pin_n), .fast_osc_ready(fast_osc_ready),
    .low_speed_internal_osc_ready(low_speed_internal_osc_ready), .fast_osc_on(fast_osc_on),
    .low_speed_internal_osc_on(low_speed_internal_osc_on), .sysclk_tick(sysclk_tick),
    .cpu_run(cpu_run), .resume_pulse(resume_pulse), .vector_pulse(vector_pulse),
    .full_reset_pulse(full_reset_pulse), .wdt_reset_pulse(wdt_reset_pulse),
    .pcsp_reset_pulse(pcsp_reset_pulse));
  osc_model u_osc (.mclk(mclk), .fast_osc_on(fast_osc_on),
    .low_speed_internal_osc_on(low_speed_internal_osc_on), .fast_osc_ready(fast_osc_ready),
    .low_speed_internal_osc_ready(low_speed_internal_osc_ready));
  // ==========================================================
  // shared tasks
  task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'h0;
    #1;
    d = reg_rdata;
  endtask
  task automatic chk(input string what, input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    cmp8(what, exp, d);
  endtask
  task automatic suspend;
    @(posedge mclk) suspend_exec <= 1'h1;
    @(posedge mclk) suspend_exec <= 1'h0;
    repeat (4) @(posedge mclk);
    #1;
  endtask
  task automatic wdt_clear;
    @(posedge mclk) watchdog_clear_instruction <= 1'h1;
    @(posedge mclk) watchdog_clear_instruction <= 1'h0;
  endtask
  // polls until the clock switch settles; bounded
  task automatic wait_sw;
    logic [7:0] d;
    d = 8'h10;
    // slowest switch is four /64 ticks plus a slow tick
    for (int i = 0; i < 300 && d[F_PEND] !== 1'h0; i++)
      rd(REG_CLK, d);
    cmp8("switch pending", 8'h00, {7'h0, d[F_PEND]});
  endtask
  // first wake pulse seen within lim cycles, zero if none
  task automatic wake_is(input int lim, input logic [3:0] exp);
    logic [3:0] s;
    s = 4'h0;
    for (int i = 0; i < lim && s === 4'h0; i++)
    begin
      @(posedge mclk);
      #1;
      s = {pcsp_reset_pulse, full_reset_pulse, vector_pulse, resume_pulse};
    end
    cmp8("wake pulse", {4'h0, exp}, {4'h0, s});
  endtask
  // ==========================================================
  // scenarios
  task automatic t_regs;
    chk("clk reset", REG_CLK, {SEL_RST, 5'h00});
    chk("stat reset", REG_STAT, 8'h00);
    chk("wake reset", REG_WAKE, 8'h00);
    chk("wdt reset", REG_WDT, {4'h0, WDT_EN_RST, WDT_SEL_RST});
    chk("mode reset", REG_MODE, {3'h0, SEL_SLOW, 2'h0});
    wr(4'h9, 8'hff);
    chk("unmapped", 4'h9, 8'h00);
    wr(REG_STAT, 8'hff);
    chk("stat read only", REG_STAT, 8'h00);
  endtask
  task automatic t_clk;
    int c;
    logic [7:0] d;
    wr(REG_CLK, 8'h00);
    rd(REG_CLK, d);
    cmp8("switch started", 8'h10, d & 8'h10);
    wait_sw;
    chk("fast stable", REG_CLK, 8'h08);
    for (int s = 1; s < 8; s++)
    begin
      wr(REG_CLK, {s[2:0], 5'h00});
      wait_sw;
      c = 0;
      // sampled after the edge, where the tick stands
      repeat (128)
      begin
        @(posedge mclk);
        #1;
        c += (sysclk_tick === 1'h1);
      end
      cmp8("tick count", (s == 7) ? 8'h20 : (8'h80 >> s), c[7:0]);
    end
    chk("fast off in slow", REG_CLK, 8'he0);
    wr(REG_CLK, 8'he4);
    repeat (40) @(posedge mclk);
    chk("fast kept in slow", REG_CLK, 8'hec);
    wr(REG_CLK, 8'h00);
    wait_sw;
  endtask
  // watchdog off so the slow oscillator follows its keep bit alone
  task automatic t_modes;
    wdt_clear;
    wr(REG_WDT, 8'h07);
    wr(REG_WAKE, 8'h02);
    for (int k = 0; k < 4; k++)
    begin
      wr(REG_CLK, {6'h00, k[1:0]});
      suspend;
      chk("stat entry", REG_STAT, 8'h02);
      chk("mode halt", REG_MODE, 8'h01);
      cmp8("fast osc", {7'h0, k[1]}, {7'h0, fast_osc_on});
      cmp8("slow osc", {7'h0, k[0]}, {7'h0, low_speed_internal_osc_on});
      @(posedge mclk) porta_pin[0] <= 1'h0;
      wake_is(20, 4'h0);
      @(posedge mclk) porta_pin[1] <= 1'h0;
      wake_is(100, 4'h1);
      @(posedge mclk) porta_pin <= 8'hff;
      chk("wake kept", REG_WAKE, 8'h02);
    end
  endtask
  task automatic t_wdt;
    logic [7:0] d;
    wr(REG_CLK, 8'h00);
    wdt_clear;
    wr(REG_WDT, 8'h08);
    repeat (600) @(posedge mclk);
    suspend;
    wake_is(880, 4'h0);
    wake_is(300, 4'h8);
    chk("stat after timeout", REG_STAT, 8'h03);
    wdt_clear;
    rd(REG_STAT, d);
    cmp8("powerdown cleared", 8'h00, d & 8'h02);
    for (int i = 0; i < 1300 && wdt_reset_pulse !== 1'h1; i++)
      @(posedge mclk) #1;
    cmp8("running timeout", 8'h01, {7'h0, wdt_reset_pulse});
    wdt_clear;
    wr(REG_WDT, 8'h07);
  endtask
  task automatic t_irq;
    @(posedge mclk) irq_req <= 4'h1;
    irq_enable <= 4'h3;
    suspend;
    chk("stat entry", REG_STAT, 8'h02);
    wake_is(30, 4'h0);
    @(posedge mclk) irq_req <= 4'h3;
    wake_is(50, 4'h2);
    for (int k = 0; k < 2; k++)
    begin
      @(posedge mclk) irq_req <= 4'h0;
      stack_full <= k[0];
      suspend;
      @(posedge mclk) irq_req <= k[0] ? 4'h2 : 4'h4;
      wake_is(50, 4'h1);
    end
    @(posedge mclk) irq_req <= 4'h0;
    stack_full <= 1'h0;
  endtask
  task automatic t_rst;
    suspend;
    @(posedge mclk) external_reset_pin_n <= 1'h0;
    wake_is(80, 4'h4);
    @(posedge mclk) external_reset_pin_n <= 1'h1;
  endtask
  task automatic test_done;
    if (n_errors == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge mclk);
    nrst <= 1'h1;
    t_regs;
    t_clk;
    t_modes;
    t_wdt;
    t_irq;
    t_rst;
    test_done;
  end
  // run needs about 5000 cycles; cut off at 40000
  initial
  begin
    #1000000;
    n_errors++;
    test_done;
  end
endmodule

// ===== watchdog_counter.sv
// watchdog counter on slow-clock ticks with selectable period
`timescale 1ns/10ps
module watchdog_counter
  import pmw_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  watchdog_link_if.core link
);
  localparam logic [WDT_CNT_W:0] UNIT = (WDT_CNT_W+1)'(1);

  logic [WDT_CNT_W-1:0] count;

  // ==========================================================
  // period decode
  wire [4:0] exp_sel = WDT_BASE_EXP + {2'h0, link.period_sel};
  wire [WDT_CNT_W:0] span = UNIT << exp_sel;
  wire [WDT_CNT_W:0] span_m1 = span - UNIT;
  wire [WDT_CNT_W-1:0] limit = span_m1[WDT_CNT_W-1:0];
  wire at_limit = count == limit;

  // ==========================================================
  // counter
  always_ff @(posedge mclk)
  begin
    // clear then count only if enabled
    if (!nrst || link.clear)
    begin
      count <= '0;
      link.overflow <= 1'b0;
    end
    else
    begin
      link.overflow <= link.enable && link.tick && at_limit;
      if (link.enable && link.tick)
      begin
        count <= at_limit ? '0 : count + 1'b1;
      end
    end
  end
endmodule

// ===== watchdog_link_if.sv
// signals between the mode controller and its watchdog counter
`timescale 1ns/10ps
interface watchdog_link_if;
  logic tick;
  logic clear;
  logic enable;
  logic [2:0] period_sel;
  logic overflow;
  modport ctl (output tick, output clear, output enable, output period_sel, input overflow);
  modport core (input tick, input clear, input enable, input period_sel, output overflow);
endinterface
